// ### dv/srr_exec_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end

module srr_exec_tb;
   import srr_pkg::*;
   localparam logic [7:0] ADD_SKIP_IMMEDIATE_OP = 8'h60;
   typedef struct packed {
      logic [7:0] b0, b1, ea;
      logic c;
      logic [7:0] pv;
      logic [3:0] m;
      logic [7:0] fol, xea;
      logic xc;
      logic [7:0] xpv;
      logic xext;
   } srr_row_type;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic fetch_valid_in = 1'b0;
   logic [7:0] fetch_byte_in = 8'h00;
   logic fetch_ready_out, redirect_out, seen;
   logic [12:0] redirect_pc_out;
   logic [7:0] mem_addr_out, mem_rdata_in;
   logic rp_we_in = 1'b0;
   logic [1:0] rp_sel_in = 2'h0;
   logic [7:0] rp_wdata_in = 8'h00;
   logic load_in = 1'b0;
   srr_state_type load_state_in = '0;
   srr_state_type state_out;
   logic [31:0] rp_flat_out;
   srr_ext_type ext_out, lx;
   logic [3:0] mem [256];
   int failures = 0;
   int n_compared = 0;
   srr_row_type r;
   // table: ops, operands, follower byte, expected results
   srr_row_type rows [12] = '{
      '{8'h88, 8'h00, 8'h55, 1'b0, 8'h00, 4'h0, 8'h01, 8'h52, 1'b1, 8'h00, 1'b1},
      '{8'h88, 8'h00, 8'h5a, 1'b1, 8'h00, 4'h0, 8'h01, 8'h5d, 1'b0, 8'h00, 1'b1},
      '{8'h3c, 8'h00, 8'h58, 1'b0, 8'h00, 4'h6, ADD_SKIP_IMMEDIATE_OP, 8'h52, 1'b0, 8'h00, 1'b0},
      '{8'h3c, 8'h00, 8'h53, 1'b0, 8'h00, 4'h4, ADD_SKIP_IMMEDIATE_OP, 8'h5f, 1'b1, 8'h00, 1'b1},
      '{8'h3c, 8'h00, 8'h58, 1'b1, 8'h00, 4'h6, 8'h01, 8'h51, 1'b0, 8'h00, 1'b1},
      '{8'h3d, 8'h00, 8'h53, 1'b1, 8'h00, 4'h4, 8'h01, 8'h5f, 1'b1, 8'h00, 1'b0},
      '{8'h3d, 8'h00, 8'h58, 1'b1, 8'h00, 4'h6, 8'h01, 8'h52, 1'b1, 8'h00, 1'b1},
      '{8'h3d, 8'h00, 8'h54, 1'b0, 8'h00, 4'h4, 8'h01, 8'h50, 1'b0, 8'h00, 1'b1},
      '{8'hdc, 8'hca, 8'hc3, 1'b1, 8'haa, 4'h0, 8'h01, 8'h18, 1'b0, 8'haa, 1'b1},
      '{8'hdc, 8'hc2, 8'h20, 1'b0, 8'h10, 4'h0, 8'h01, 8'h20, 1'b1, 8'hf0, 1'b1},
      '{8'hdc, 8'hba, 8'hc3, 1'b0, 8'hc7, 4'h0, 8'h01, 8'hfc, 1'b0, 8'hc7, 1'b0},
      '{8'hdc, 8'hb2, 8'h0a, 1'b1, 8'haf, 4'h0, 8'h01, 8'h0a, 1'b1, 8'ha5, 1'b1}
   };

   assign mem_rdata_in = {mem[mem_addr_out + 8'h01], mem[mem_addr_out]};

   always #12.5 clk_in = ~clk_in;

   srr_exec #(.ADS_OPCODE(ADD_SKIP_IMMEDIATE_OP), .PAIRS(4)) DUT (
      .clk_in(clk_in), .rst_in(rst_in), .fetch_valid_in(fetch_valid_in),
      .fetch_byte_in(fetch_byte_in), .fetch_ready_out(fetch_ready_out),
      .redirect_out(redirect_out), .redirect_pc_out(redirect_pc_out),
      .mem_addr_out(mem_addr_out), .mem_rdata_in(mem_rdata_in), .rp_we_in(rp_we_in),
      .rp_sel_in(rp_sel_in), .rp_wdata_in(rp_wdata_in), .load_in(load_in),
      .load_state_in(load_state_in), .state_out(state_out), .rp_flat_out(rp_flat_out),
      .ext_out(ext_out)
   );

   task print_verdict;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   task issue(input logic [7:0] b);
      int i;
      fetch_valid_in <= 1'b1;
      fetch_byte_in <= b;
      for (i = 0; i < 20; i++) begin
         @(negedge clk_in);
         if (fetch_ready_out === 1'b1) break;
      end
      if (i == 20) begin
         failures++;
         print_verdict();
      end
      @(posedge clk_in);
   endtask : issue

   task ld(input logic [7:0] sp, ea, input logic c, input logic [1:0] sel,
      input logic [7:0] pv);
      load_in <= 1'b1;
      load_state_in <= '{13'h0000, sp, ea, c, 1'b0, 1'b0};
      rp_we_in <= 1'b1;
      rp_sel_in <= sel;
      rp_wdata_in <= pv;
      @(posedge clk_in);
      load_in <= 1'b0;
      rp_we_in <= 1'b0;
   endtask : ld

   task watch;
      seen = 1'b0;
      lx = '0;
      repeat (4) begin
         @(negedge clk_in);
         if (ext_out.valid === 1'b1) begin
            seen = 1'b1;
            lx = ext_out;
         end
      end
      @(posedge clk_in);
   endtask : watch

   task rst_chk;
      rst_in <= 1'b1;
      repeat (12) @(posedge clk_in);
      rst_in <= 1'b0;
      @(negedge clk_in);
      `CHK(state_out, 32'h0)
      `CHK(rp_flat_out, 32'h0)
      `CHK(fetch_ready_out, 1'b1)
      @(posedge clk_in);
   endtask : rst_chk

   task ret(input logic [7:0] sp, input logic [12:0] xpc, input logic [1:0] xf);
      int k;
      int lo;
      ld(sp, 8'h00, 1'b0, 2'h1, 8'h00);
      issue(8'hc5);
      fetch_valid_in <= 1'b0;
      k = 0;
      lo = 0;
      seen = 1'b0;
      while (seen !== 1'b1 && k < 8) begin
         @(negedge clk_in);
         k++;
         lo += (fetch_ready_out === 1'b0);
         seen = redirect_out;
      end
      `CHK(k, 3)
      `CHK(lo, 3)
      `CHK(redirect_pc_out, xpc)
      repeat (2) @(negedge clk_in);
      `CHK(state_out.sp, sp + 8'h06)
      `CHK({state_out.memory_bank_enable_flag, state_out.register_bank_enable_flag}, xf)
      @(posedge clk_in);
   endtask : ret

   initial begin
      foreach (mem[i]) mem[i] = 4'h0;
      {mem[8'hfa], mem[8'hfb], mem[8'hfc], mem[8'hfd], mem[8'hfe]} = 20'h10523;
      {mem[8'h10], mem[8'h11], mem[8'h12], mem[8'h13], mem[8'h14]} = 20'hf10a2;
      rst_chk();
      ld(8'h00, 8'h00, 1'b0, 2'h3, 8'h40);
      foreach (rows[i]) begin
         r = rows[i];
         ld(8'h00, r.ea, r.c, 2'h1, r.pv);
         mem[8'h40] = r.m;
         issue(r.b0);
         if (r.b1 !== 8'h00) issue(r.b1);
         issue(r.fol);
         fetch_valid_in <= 1'b0;
         watch();
         `CHK(state_out.ea, r.xea)
         `CHK(state_out.carry, r.xc)
         `CHK(rp_flat_out[15:8], r.xpv)
         `CHK(seen, r.xext)
         `CHK(lx.no_ovf_skip, r.xext && r.b0 == 8'h3c && r.fol == ADD_SKIP_IMMEDIATE_OP)
      end
      // skipped prefixed instruction consumes both bytes
      ld(8'h00, 8'h53, 1'b0, 2'h1, 8'h10);
      mem[8'h40] = 4'h4;
      issue(8'h3d);
      issue(8'hdc);
      issue(8'hc2);
      issue(8'h01);
      fetch_valid_in <= 1'b0;
      watch();
      `CHK(state_out.ea, 8'h5f)
      `CHK(rp_flat_out[15:8], 8'h10)
      `CHK(seen, 1'b1)
      `CHK(lx.code, 8'h01)
      ret(8'hfa, 13'h0125, 2'b11);
      ret(8'h10, 13'h1fa0, 2'b10);
      issue(8'hdc);
      issue(8'h51);
      fetch_valid_in <= 1'b0;
      watch();
      `CHK(lx.prefixed, 1'b1)
      `CHK(lx.code, 8'h51)
      ld(8'h33, 8'h77, 1'b1, 2'h2, 8'h99);
      rst_chk();
      print_verdict();
   end
endmodule : srr_exec_tb

// ### inc/srr_map.svh
`ifndef SRR_MAP_SVH
`define SRR_MAP_SVH

// opcode bytes
`define SRR_OP_RETURN 8'hc5
`define SRR_OP_ROTATE 8'h88
`define SRR_OP_SBC_MEM 8'h3c
`define SRR_OP_SBS_MEM 8'h3d
`define SRR_OP_PREFIX 8'hdc
// default add-skip opcode, arbitrary neutral value
`define SRR_OP_ADS 8'h00

// second byte of the prefixed forms
`define SRR_SUB_SBC 4'hc
`define SRR_SUB_SBS 4'hb
`define SRR_SUB_HI 7
`define SRR_SUB_LO 4
`define SRR_DIR_BIT 3
`define SRR_IDX_HI 2
`define SRR_IDX_LO 1
`define SRR_ZERO_BIT 0

// stack frame layout
`define SRR_FRAME_MID 8'h02
`define SRR_FRAME_FLAGS 8'h04
`define SRR_FRAME_SIZE 8'h06
`define SRR_PC12_BIT 4
`define SRR_EMB_BIT 1
`define SRR_ERB_BIT 0

// pair used as the memory pointer
`define SRR_HL_PAIR 2'h3

// reset values
`define SRR_RST_PC 13'h0000
`define SRR_RST_SP 8'h00
`define SRR_RST_EA 8'h00
`define SRR_RST_PAIR 8'h00

`endif

// ### inc/srr_pkg.sv
package srr_pkg;

   typedef enum logic [2:0] {
      SRR_DECODE,
      SRR_PREFIX,
      SRR_RET1,
      SRR_RET2,
      SRR_SKIP2
   } srr_fsm_type;

   typedef struct packed {
      logic [12:0] pc;
      logic [7:0] sp;
      logic [7:0] ea;
      logic carry;
      logic memory_bank_enable_flag;
      logic register_bank_enable_flag;
   } srr_state_type;

   typedef struct packed {
      logic valid;
      logic prefixed;
      logic [7:0] code;
      logic no_ovf_skip;
   } srr_ext_type;

endpackage : srr_pkg

// ### rtl/srr_exec.sv
// Overview of operation
// RULE1 - return: one byte, three cycles, sp plus six
// RULE2 - return frame restores pc and bank flags
// RULE3 - fetch resumes at the restored pc
// RULE4 - rotate accumulator right through carry
// RULE5 - rotate is one byte, one cycle
// RULE6 - subtract with borrow sets carry on borrow
// RULE7 - subtract with borrow: memory and pair forms
// RULE8 - memory form no-borrow skips following add
// RULE9 - pair forms of borrow subtract never skip
// RULE10 - skip subtract ignores and keeps carry
// RULE11 - skip subtract skips next on borrow
// RULE12 - skip subtract: memory and pair forms
// RULE13 - decode 0x3c and prefix with 1100
// RULE14 - decode 0x3d and prefix with 1011
// RULE15 - decode 0xc5 return, 0x88 rotate
// RULE16 - r2 r1 selects one of four pairs
`timescale 1ns/1ps
`include "srr_map.svh"

module srr_exec #(
   parameter logic [7:0] ADS_OPCODE = `SRR_OP_ADS,
   parameter int PAIRS = 4
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic fetch_valid_in,
   input wire logic [7:0] fetch_byte_in,
   output logic fetch_ready_out,
   output logic redirect_out,
   output logic [12:0] redirect_pc_out,
   output logic [7:0] mem_addr_out,
   input wire logic [7:0] mem_rdata_in,
   input wire logic rp_we_in,
   input wire logic [1:0] rp_sel_in,
   input wire logic [7:0] rp_wdata_in,
   input wire logic load_in,
   input wire srr_pkg::srr_state_type load_state_in,
   output srr_pkg::srr_state_type state_out,
   output logic [31:0] rp_flat_out,
   output srr_pkg::srr_ext_type ext_out
);
   import srr_pkg::*;

   generate
      if (PAIRS != 4) begin : g_bad
         $error("srr_exec serves exactly four register pairs");
      end
   endgenerate

   srr_fsm_type fsm;
   srr_state_type st;
   logic [7:0] rp [PAIRS];
   logic skip_pend;
   logic after_sbc;
   logic sbc_no_borrow;

   logic take;
   logic in_dec;
   logic is_ads;
   logic skip_now;
   logic do_op;
   logic in_pre;
   logic [3:0] sub_code;
   logic pre_dir;
   logic [1:0] pre_idx;
   logic pre_sbc;
   logic pre_sbs;
   logic pre_hit;
   logic ex_rrc;
   logic ex_sbcm;
   logic ex_sbsm;
   logic ex_ret;
   logic [3:0] nib_diff;
   logic nib_borrow;
   logic [7:0] wide_dst;
   logic [7:0] wide_src;
   logic [7:0] wide_diff;
   logic wide_borrow;

   // pair index from r2 r1, pairs are even aligned
   function automatic logic [1:0] pair_index(input logic [7:0] code);
      pair_index = code[`SRR_IDX_HI:`SRR_IDX_LO];
   endfunction : pair_index

   always_comb begin
      fetch_ready_out = ((fsm == SRR_DECODE) || (fsm == SRR_PREFIX) ||
                         (fsm == SRR_SKIP2)) && !redirect_out;
      take = fetch_valid_in && fetch_ready_out;
      in_dec = take && (fsm == SRR_DECODE);
      in_pre = take && (fsm == SRR_PREFIX);
      is_ads = (fetch_byte_in == ADS_OPCODE);
      // RULE8 add skipped
      skip_now = skip_pend || (after_sbc && sbc_no_borrow && is_ads);
      do_op = in_dec && !skip_now;
      // RULE15 fixed opcodes
      ex_ret = do_op && (fetch_byte_in == `SRR_OP_RETURN);
      // RULE5 rotate done in decode cycle
      ex_rrc = do_op && (fetch_byte_in == `SRR_OP_ROTATE);
      // RULE13 memory borrow form
      ex_sbcm = do_op && (fetch_byte_in == `SRR_OP_SBC_MEM);
      // RULE14 memory skip form
      ex_sbsm = do_op && (fetch_byte_in == `SRR_OP_SBS_MEM);
      sub_code = fetch_byte_in[`SRR_SUB_HI:`SRR_SUB_LO];
      pre_dir = fetch_byte_in[`SRR_DIR_BIT];
      pre_idx = pair_index(fetch_byte_in);
      // RULE13 prefixed borrow form
      pre_sbc = in_pre && (sub_code == `SRR_SUB_SBC) && !fetch_byte_in[`SRR_ZERO_BIT];
      // RULE14 prefixed skip form
      pre_sbs = in_pre && (sub_code == `SRR_SUB_SBS) && !fetch_byte_in[`SRR_ZERO_BIT];
      pre_hit = pre_sbc || pre_sbs;
   end

   // operand select for pair forms
   always_comb begin
      wide_dst = pre_dir ? st.ea : rp[pre_idx];
      wide_src = pre_dir ? rp[pre_idx] : st.ea;
   end

   // return frame and pointer fetch
   always_comb begin
      unique case (fsm)
         SRR_RET1: mem_addr_out = st.sp + `SRR_FRAME_MID;
         SRR_RET2: mem_addr_out = st.sp + `SRR_FRAME_FLAGS;
         default: mem_addr_out = (fetch_byte_in == `SRR_OP_RETURN) ? st.sp :
                                 rp[`SRR_HL_PAIR];
      endcase
   end

   // RULE10 no carry into skip subtract
   srr_sub #(.W(4)) u_nib (
      .dst_in(st.ea[3:0]),
      .src_in(mem_rdata_in[3:0]),
      .borrow_in(st.carry && (fetch_byte_in == `SRR_OP_SBC_MEM)),
      .diff_out(nib_diff),
      .borrow_out(nib_borrow)
   );

   srr_sub #(.W(8)) u_wide (
      .dst_in(wide_dst),
      .src_in(wide_src),
      .borrow_in(st.carry && (sub_code == `SRR_SUB_SBC)),
      .diff_out(wide_diff),
      .borrow_out(wide_borrow)
   );

   // sequencing
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         fsm <= SRR_DECODE;
      end else begin
         unique case (fsm)
            SRR_DECODE: begin
               if (in_dec && skip_now && (fetch_byte_in == `SRR_OP_PREFIX)) begin
                  fsm <= SRR_SKIP2;
               end else if (ex_ret) begin
                  fsm <= SRR_RET1;
               end else if (do_op && (fetch_byte_in == `SRR_OP_PREFIX)) begin
                  fsm <= SRR_PREFIX;
               end
            end
            SRR_PREFIX: if (take) fsm <= SRR_DECODE;
            // RULE1 three cycle return
            SRR_RET1: fsm <= SRR_RET2;
            SRR_RET2: fsm <= SRR_DECODE;
            SRR_SKIP2: if (take) fsm <= SRR_DECODE;
         endcase
      end
   end

   // architectural state
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st <= '{pc: `SRR_RST_PC, sp: `SRR_RST_SP, ea: `SRR_RST_EA,
                 carry: 1'b0, memory_bank_enable_flag: 1'b0, register_bank_enable_flag: 1'b0};
      end else if (load_in) begin
         st <= load_state_in;
      end else begin
         if (take) begin
            st.pc <= st.pc + 13'h0001;
         end
         // RULE2 frame head
         if (ex_ret) begin
            st.pc[12:8] <= {mem_rdata_in[`SRR_PC12_BIT], mem_rdata_in[3:0]};
         end
         if (fsm == SRR_RET1) begin
            st.pc[7:0] <= {mem_rdata_in[7:4], mem_rdata_in[3:0]};
         end
         // RULE1 pop frame
         if (fsm == SRR_RET2) begin
            st.memory_bank_enable_flag <= mem_rdata_in[`SRR_EMB_BIT];
            st.register_bank_enable_flag <= mem_rdata_in[`SRR_ERB_BIT];
            st.sp <= st.sp + `SRR_FRAME_SIZE;
         end
         // RULE4 rotate through carry
         if (ex_rrc) begin
            st.carry <= st.ea[0];
            st.ea[3:0] <= {st.carry, st.ea[3:1]};
         end
         // RULE6 memory borrow subtract
         if (ex_sbcm) begin
            st.ea[3:0] <= nib_diff;
            st.carry <= nib_borrow;
         end
         // RULE12 memory skip subtract result
         if (ex_sbsm) begin
            st.ea[3:0] <= nib_diff;
         end
         // RULE7 extended destination
         if (pre_hit && pre_dir) begin
            st.ea <= wide_diff;
         end
         if (pre_sbc) begin
            st.carry <= wide_borrow;
         end
      end
   end

   // working register pairs
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < PAIRS; i++) begin
            rp[i] <= `SRR_RST_PAIR;
         end
      end else if (pre_hit && !pre_dir) begin
         // RULE16 selected pair written
         rp[pre_idx] <= wide_diff;
      end else if (rp_we_in) begin
         rp[rp_sel_in] <= rp_wdata_in;
      end
   end

   // skip and add-adjust tracking
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         skip_pend <= 1'b0;
         after_sbc <= 1'b0;
         sbc_no_borrow <= 1'b0;
      end else begin
         if (in_dec) begin
            // RULE11 skip on borrow
            skip_pend <= ex_sbsm && nib_borrow;
            after_sbc <= ex_sbcm;
            sbc_no_borrow <= ex_sbcm && !nib_borrow;
         end else if (in_pre) begin
            // RULE9 borrow subtract never skips
            skip_pend <= pre_sbs && wide_borrow;
            after_sbc <= 1'b0;
            sbc_no_borrow <= 1'b0;
         end
      end
   end

   // foreign instructions and return redirect
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ext_out <= '0;
         redirect_out <= 1'b0;
      end else begin
         // RULE3 resume at restored pc
         redirect_out <= (fsm == SRR_RET2);
         ext_out.valid <= (do_op && !ex_ret && !ex_rrc && !ex_sbcm && !ex_sbsm &&
                           (fetch_byte_in != `SRR_OP_PREFIX)) || (in_pre && !pre_hit);
         ext_out.prefixed <= in_pre;
         ext_out.code <= fetch_byte_in;
         // RULE8 add overflow skip inhibited
         ext_out.no_ovf_skip <= in_dec && after_sbc && is_ads;
      end
   end

   always_comb begin
      redirect_pc_out = st.pc;
      state_out = st;
      rp_flat_out = {rp[3], rp[2], rp[1], rp[0]};
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   ret_cycles_a: assert property (fsm == SRR_RET2 |-> // RULE1
      $past(fsm) == SRR_RET1 && $past(fsm, 2) == SRR_DECODE)
      else $error("return did not take three cycles");
   ret_sp_a: assert property ((fsm == SRR_RET2) && !load_in |=> // RULE1
      st.sp == 8'($past(st.sp) + 8'h06))
      else $error("stack pointer not advanced by six");
   ret_redirect_a: assert property (ex_ret && !load_in |-> ##3 // RULE3
      redirect_out && redirect_pc_out == st.pc && !fetch_ready_out)
      else $error("return redirect missing");
   rotate_bits_a: assert property (ex_rrc && !load_in |=> // RULE4
      st.carry == $past(st.ea[0]) && st.ea[3:0] == {$past(st.carry), $past(st.ea[3:1])})
      else $error("rotate through carry wrong");
   rotate_one_a: assert property (ex_rrc |=> fsm == SRR_DECODE) // RULE5
      else $error("rotate took more than one cycle");
   sbc_carry_a: assert property (ex_sbcm && !load_in |=> // RULE6
      st.carry == $past(nib_borrow) &&
      st.ea[3:0] == 4'($past(st.ea[3:0]) - $past(mem_rdata_in[3:0]) - $past(st.carry)))
      else $error("borrow subtract result wrong");
   sbs_keep_a: assert property ((ex_sbsm || pre_sbs) && !load_in |=> // RULE10
      st.carry == $past(st.carry))
      else $error("skip subtract changed carry");
   pair_noskip_a: assert property (pre_sbc |=> !skip_pend) // RULE9
      else $error("pair borrow subtract caused a skip");
   sbs_skip_a: assert property (ex_sbsm && nib_borrow |=> skip_pend) // RULE11
      else $error("skip subtract did not skip on borrow");
   ads_skip_a: assert property (in_dec && after_sbc && sbc_no_borrow && is_ads // RULE8
      |=> !ext_out.valid)
      else $error("add after no-borrow subtract not skipped");

endmodule : srr_exec

// ### rtl/srr_sub.sv
`timescale 1ns/1ps

module srr_sub #(
   parameter int W = 8
) (
   input wire logic [W-1:0] dst_in,
   input wire logic [W-1:0] src_in,
   input wire logic borrow_in,
   output logic [W-1:0] diff_out,
   output logic borrow_out
);

   logic [W:0] full;

   generate
      if (W < 1) begin : g_bad
         $error("srr_sub width must be positive");
      end
   endgenerate

   // borrow out of the top bit
   always_comb begin
      full = {1'b0, dst_in} - {1'b0, src_in} - {{W{1'b0}}, borrow_in};
      diff_out = full[W-1:0];
      borrow_out = full[W];
   end

endmodule : srr_sub
